//--- shared/ftsc_pkg.sv
package ftsc_pkg;
  timeunit 1ns;
  timeprecision 1ns;
  // geometry of the array and the pins
  localparam int ADDR_W = 17;
  localparam int LANES = 2;
  localparam int LANE_W = 9;
  localparam int DATA_W = LANES * LANE_W;
  localparam int BURST_W = 2;
  localparam int FIFO_DEPTH = 32;
  localparam int MEM_DEPTH = 1 << ADDR_W;
  // sleep entry and exit each take this many clocks
  localparam int SLEEP_CYC = 2;
  localparam logic [1:0] SLEEP_CNT_RST = 2'h0;
  localparam logic [BURST_W-1:0] BURST_RST = 2'h0;

  typedef enum logic [1:0] {
    FTSC_IDLE,
    FTSC_READ,
    FTSC_WRITE
  } ftsc_op_e;

  // one write beat, carried from capture through the fifo to the array
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] lane_en;
    logic [DATA_W-1:0] data;
  } ftsc_wbeat_s;

  localparam int WBEAT_W = $bits(ftsc_wbeat_s);
endpackage

//--- logic/ftsc_fifo.sv
// synchronous fifo, registered read data, honest full and empty
module ftsc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk_sys, // system clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic in_valid, // write side offers a word
  output logic in_ready, // fifo can take a word
  input wire logic [WIDTH-1:0] in_data, // word to store
  output logic out_valid, // head word available
  input wire logic out_ready, // drain side takes the head
  output logic [WIDTH-1:0] out_data // head word, registered
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [WIDTH-1:0] out_data_reg, out_data_next;
  logic ov_reg, ov_next;
  logic do_wr, do_rd, stored;

  // pointers carry one wrap bit so full and empty are exact
  always_comb begin
    stored = (wp_reg != rp_reg);
    in_ready = (wp_reg[PW-1:0] != rp_reg[PW-1:0]) || (wp_reg[PW] == rp_reg[PW]);
    do_wr = in_valid && in_ready;
    do_rd = stored && (!ov_reg || out_ready);
    wp_next = do_wr ? wp_reg + 1'b1 : wp_reg;
    rp_next = do_rd ? rp_reg + 1'b1 : rp_reg;
    ov_next = do_rd ? 1'b1 : (out_ready ? 1'b0 : ov_reg);
    out_data_next = do_rd ? mem[rp_reg[PW-1:0]] : out_data_reg;
  end

  // storage has no reset; only pointers and the valid flag need a defined value
  always_ff @(posedge clk_sys) begin
    if (do_wr) begin
      mem[wp_reg[PW-1:0]] <= in_data;
    end
    if (sys_rst) begin
      wp_reg <= '0;
      rp_reg <= '0;
      ov_reg <= 1'b0;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      ov_reg <= ov_next;
    end
    out_data_reg <= out_data_next;
  end

  assign out_valid = ov_reg;
  assign out_data = out_data_reg;
endmodule

//--- logic/ftsc_array.sv
// the storage array with per-lane write and registered read port
module ftsc_array (
  input wire logic clk_sys, // system clock
  input wire logic [ftsc_pkg::ADDR_W-1:0] rd_addr, // read address
  output logic [ftsc_pkg::DATA_W-1:0] rd_data, // read data, registered
  input wire logic wr_en, // write strobe
  input wire logic [ftsc_pkg::ADDR_W-1:0] wr_addr, // write address
  input wire logic [ftsc_pkg::LANES-1:0] wr_lane, // lanes to store
  input wire logic [ftsc_pkg::DATA_W-1:0] wr_data // write data
);
  timeunit 1ns;
  timeprecision 1ns;
  // each lane, data bits and parity bit together, owns its storage and strobe,
  // so no two processes ever write the same memory
  for (genvar g = 0; g < ftsc_pkg::LANES; g++) begin : g_lane
    logic [ftsc_pkg::LANE_W-1:0] mem [ftsc_pkg::MEM_DEPTH];
    logic [ftsc_pkg::LANE_W-1:0] rd_lane_reg;
    always_ff @(posedge clk_sys) begin
      if (wr_en && wr_lane[g]) begin
        mem[wr_addr] <= wr_data[g*ftsc_pkg::LANE_W +: ftsc_pkg::LANE_W];
      end
      rd_lane_reg <= mem[rd_addr];
    end
    // read port is registered per lane
    assign rd_data[g*ftsc_pkg::LANE_W +: ftsc_pkg::LANE_W] = rd_lane_reg;
  end
endmodule

//--- logic/ftsc_core.sv
// Functional notes
// R1: enabled edge, selects active, load low, write high starts read burst
// R2: load high during read ignores selects, advances burst, drives data
// R3: read start with output enable high is a dummy read, pins float
// R4: read continue with output enable high advances silently, pins float
// R5: enabled edge, selects active, load low, write low, some lane starts write
// R6: load high in write burst with some lane advances and takes data
// R7: write start with no lane selected aborts, nothing stored, pins float
// R8: write continue with no lane selected advances, writes nothing
// R9: clock enable high ignores the edge, all state holds; the code keeps the sleep logic and write fifo drain running
// R10: each lane with parity is written only under its own select
// R11: any write cycle floats all data and parity pins
// R12: output enable acts combinationally, never sampled
// R13: output enable is masked during write cycles
// R14: read pins float when disabled or deselected, else carry data
// R15: after power-up the device is deselected with pins floating
// R16: inactive select with load low deselects, outputs float at once
// R17: sleep request floats pins; entry and exit take two clocks
// R18: burst steps two low address bits, linear or interleaved, wrapping
// R19: write data arrives the edge after the command and is latched then
// R20: load high while deselected stays deselected
module ftsc_core (
  input wire logic clk_sys, // system clock
  input wire logic sys_rst, // synchronous reset, stands for power-up
  input wire logic [ftsc_pkg::ADDR_W-1:0] addr_in, // external address
  input wire logic chip_sel_a_n, // chip select, low active
  input wire logic chip_sel_b_hi, // chip select, high active
  input wire logic chip_sel_c_n, // chip select, low active
  input wire logic advance_load_ctl, // high advances, low loads
  input wire logic write_en_n, // low for write
  input wire logic byte_write_sel_lane_a_n, // lane a write select, low
  input wire logic byte_write_sel_lane_b_n, // lane b write select, low
  input wire logic out_en_n, // asynchronous output enable, low
  input wire logic clk_en_n, // clock enable, low
  input wire logic sleep_req, // asynchronous sleep request
  input wire logic burst_order_sel, // low linear, high interleaved
  input wire logic [ftsc_pkg::DATA_W-1:0] data_in, // data and parity pins in
  output logic [ftsc_pkg::DATA_W-1:0] data_out, // data and parity pins out
  output logic data_oe, // high while driving data pins
  output logic sleep_active // sleep state reached
);
  timeunit 1ns;
  timeprecision 1ns;
  // sleep and order come from pins off the clock domain
  logic sleep_s1_reg, sleep_s2_reg, order_s1_reg, order_s2_reg;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sleep_s1_reg <= 1'b0;
      sleep_s2_reg <= 1'b0;
      order_s1_reg <= 1'b0;
      order_s2_reg <= 1'b0;
    end else begin
      sleep_s1_reg <= sleep_req;
      sleep_s2_reg <= sleep_s1_reg;
      order_s1_reg <= burst_order_sel;
      order_s2_reg <= order_s1_reg;
    end
  end

  // burst step: linear adds the beat count, interleaved xors it
  function automatic logic [ftsc_pkg::BURST_W-1:0] burst_step(
    input logic [ftsc_pkg::BURST_W-1:0] start,
    input logic [ftsc_pkg::BURST_W-1:0] beat,
    input logic interleave
  );
    logic [ftsc_pkg::BURST_W-1:0] r;
    r = interleave ? (start ^ beat) : (start + beat);
    return r;
  endfunction

  ftsc_pkg::ftsc_op_e op_reg, op_next;
  logic [ftsc_pkg::ADDR_W-1:0] base_reg, base_next;
  logic [ftsc_pkg::BURST_W-1:0] beat_reg, beat_next;
  logic [ftsc_pkg::LANES-1:0] lane_reg, lane_next;
  logic wpend_reg, wpend_next;
  logic [ftsc_pkg::ADDR_W-1:0] waddr_reg, waddr_next;
  logic [1:0] sleep_cnt_reg, sleep_cnt_next;
  logic sleep_reg, sleep_next;
  logic [ftsc_pkg::LANES-1:0] sel_lane;
  logic all_sel, any_lane, stall, cur_write;
  logic [ftsc_pkg::ADDR_W-1:0] cur_addr;
  logic [ftsc_pkg::ADDR_W-1:0] rd_addr;
  logic fifo_in_ready, fifo_out_valid;
  ftsc_pkg::ftsc_wbeat_s wbeat_in, wbeat_out;
  logic [ftsc_pkg::DATA_W-1:0] arr_rd;

  // input decode
  always_comb begin
    sel_lane = ~{byte_write_sel_lane_b_n, byte_write_sel_lane_a_n};
    any_lane = |sel_lane;
    all_sel = !chip_sel_a_n && chip_sel_b_hi && !chip_sel_c_n;
    // R9: stall holds the cycle decode state unless asleep; a full write fifo also stalls the core
    stall = clk_en_n || sleep_reg || !fifo_in_ready;
    cur_addr = {base_reg[ftsc_pkg::ADDR_W-1:ftsc_pkg::BURST_W],
                burst_step(base_reg[ftsc_pkg::BURST_W-1:0], beat_reg, order_s2_reg)};
  end

  // sleep entry and exit counter
  always_comb begin
    sleep_next = sleep_reg;
    sleep_cnt_next = ftsc_pkg::SLEEP_CNT_RST;
    // R17: two clocks to enter or leave sleep
    if (sleep_s2_reg != sleep_reg) begin
      sleep_cnt_next = sleep_cnt_reg + 2'h1;
      if (sleep_cnt_reg == 2'(ftsc_pkg::SLEEP_CYC - 1)) begin
        sleep_next = sleep_s2_reg;
        sleep_cnt_next = ftsc_pkg::SLEEP_CNT_RST;
      end
    end
  end

  // cycle decode
  always_comb begin
    op_next = op_reg;
    base_next = base_reg;
    beat_next = beat_reg;
    lane_next = lane_reg;
    wpend_next = 1'b0;
    waddr_next = waddr_reg;
    if (sleep_reg) begin
      // sleep drops any pending access and lands deselected
      op_next = ftsc_pkg::FTSC_IDLE;
    end else if (!stall) begin
      if (!advance_load_ctl) begin
        if (!all_sel) begin
          // R16: deselect on inactive select
          op_next = ftsc_pkg::FTSC_IDLE;
        end else if (write_en_n) begin
          // R1: read start latches address
          op_next = ftsc_pkg::FTSC_READ;
          base_next = addr_in;
          beat_next = ftsc_pkg::BURST_RST;
        end else begin
          // R5: write start; R7: no lane means abort
          op_next = ftsc_pkg::FTSC_WRITE;
          base_next = addr_in;
          beat_next = ftsc_pkg::BURST_RST;
          lane_next = sel_lane;
          wpend_next = any_lane;
          waddr_next = addr_in;
        end
      end else if (op_reg != ftsc_pkg::FTSC_IDLE) begin
        // R2: advance ignores selects and write enable
        // R18: step the low two bits, wrapping
        beat_next = beat_reg + 2'h1;
        if (op_reg == ftsc_pkg::FTSC_WRITE) begin
          // R6: continue write; R8: no lane writes nothing
          lane_next = sel_lane;
          wpend_next = any_lane;
          waddr_next = {base_reg[ftsc_pkg::ADDR_W-1:ftsc_pkg::BURST_W],
                        burst_step(base_reg[ftsc_pkg::BURST_W-1:0], beat_reg + 2'h1, order_s2_reg)};
        end
      end
      // R20: advance while idle keeps idle
    end else begin
      // held write beat is kept across a stall
      wpend_next = wpend_reg;
    end
  end

  // R15: reset lands deselected
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      op_reg <= ftsc_pkg::FTSC_IDLE;
      base_reg <= '0;
      beat_reg <= ftsc_pkg::BURST_RST;
      lane_reg <= '0;
      wpend_reg <= 1'b0;
      waddr_reg <= '0;
      sleep_reg <= 1'b0;
      sleep_cnt_reg <= ftsc_pkg::SLEEP_CNT_RST;
    end else begin
      op_reg <= op_next;
      base_reg <= base_next;
      beat_reg <= beat_next;
      lane_reg <= lane_next;
      wpend_reg <= wpend_next;
      waddr_reg <= waddr_next;
      sleep_reg <= sleep_next;
      sleep_cnt_reg <= sleep_cnt_next;
    end
  end

  // R19: data is taken on the edge after the command, then queued
  // R10: the lane selects travel with the beat so the array writes only those lanes
  always_comb begin
    wbeat_in.addr = waddr_reg;
    wbeat_in.lane_en = lane_reg;
    wbeat_in.data = data_in;
  end

  // the fifo decouples pin capture from array writes; the drain
  // side only pauses while a read needs the port, giving back-pressure
  ftsc_fifo #(
    .WIDTH(ftsc_pkg::WBEAT_W),
    .DEPTH(ftsc_pkg::FIFO_DEPTH)
  ) u_wfifo (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .in_valid(wpend_reg && !clk_en_n),
    .in_ready(fifo_in_ready),
    .in_data(wbeat_in),
    .out_valid(fifo_out_valid),
    .out_ready(op_reg != ftsc_pkg::FTSC_READ),
    .out_data(wbeat_out)
  );

  // array read address for the coming cycle so array data lands with the op;
  // a process rather than a call in the port, so every next-state change is seen
  always_comb begin
    rd_addr = cur_addr;
    if (op_next == ftsc_pkg::FTSC_READ) begin
      rd_addr = {base_next[ftsc_pkg::ADDR_W-1:ftsc_pkg::BURST_W],
                 burst_step(base_next[ftsc_pkg::BURST_W-1:0], beat_next, order_s2_reg)};
    end
  end

  ftsc_array u_array (
    .clk_sys(clk_sys),
    .rd_addr(rd_addr),
    .rd_data(arr_rd),
    .wr_en(fifo_out_valid && op_reg != ftsc_pkg::FTSC_READ),
    .wr_addr(wbeat_out.addr),
    .wr_lane(wbeat_out.lane_en),
    .wr_data(wbeat_out.data)
  );

  // pin drive follows the current cycle and the live output enable
  always_comb begin
    cur_write = (op_reg == ftsc_pkg::FTSC_WRITE);
    data_out = arr_rd;
    // R12: output enable is used raw, no flop
    // R13: R11: write cycles mask output enable
    // R3: R4: R14: read with enable high floats; R17: sleep floats
    data_oe = (op_reg == ftsc_pkg::FTSC_READ) && !cur_write && !out_en_n && !sleep_reg;
    sleep_active = sleep_reg;
  end
endmodule

//--- dv/ftsc_core_props.sv
module ftsc_core_props (
  input wire logic clk_sys, // clock
  input wire logic sys_rst, // reset
  input wire logic [ftsc_pkg::ADDR_W-1:0] addr_in, // address
  input wire logic chip_sel_a_n, // select a
  input wire logic chip_sel_b_hi, // select b
  input wire logic chip_sel_c_n, // select c
  input wire logic advance_load_ctl, // advance or load
  input wire logic write_en_n, // write
  input wire logic byte_write_sel_lane_a_n, // lane a
  input wire logic byte_write_sel_lane_b_n, // lane b
  input wire logic out_en_n, // output enable
  input wire logic clk_en_n, // clock enable
  input wire logic sleep_req, // sleep
  input wire logic burst_order_sel, // order
  input wire logic [ftsc_pkg::DATA_W-1:0] data_in, // pins in
  input wire logic [ftsc_pkg::DATA_W-1:0] data_out, // pins out
  input wire logic data_oe, // pins driven
  input wire logic sleep_active // asleep
);
  timeunit 1ns;
  timeprecision 1ns;
  logic en, sel, rd_go, wr_go;
  // decoded command, only meaningful on a live, awake edge
  assign en = !clk_en_n && !sleep_req && !sleep_active;
  assign sel = !chip_sel_a_n && chip_sel_b_hi && !chip_sel_c_n;
  assign rd_go = en && sel && !advance_load_ctl && write_en_n;
  assign wr_go = en && sel && !advance_load_ctl && !write_en_n;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  chk_write_float: assert property (wr_go |=> !data_oe)
    else $error("pins driven after write start");
  chk_write_beat: assert property (wr_go ##1 (en && advance_load_ctl) |=> !data_oe)
    else $error("pins driven in write beat");
  chk_oe_gate: assert property (out_en_n |-> !data_oe)
    else $error("pins driven with output enable off");
  chk_read_drive: assert property (rd_go |=> out_en_n || data_oe)
    else $error("read start not driven");
  chk_burst_drive: assert property (rd_go ##1 (en && advance_load_ctl) |=> out_en_n || data_oe)
    else $error("read beat not driven");
  chk_stall_hold: assert property ($past(clk_en_n) && $stable(out_en_n) && $stable(sleep_active)
    |-> $stable(data_oe))
    else $error("stalled edge changed drive");
  chk_desel_float: assert property (en && !advance_load_ctl && !sel |=> !data_oe)
    else $error("deselect still drives");
  chk_idle_advance: assert property ((en && !advance_load_ctl && !sel) ##1 (en && advance_load_ctl)
    |=> !data_oe)
    else $error("advance left deselect");
  chk_sleep_float: assert property (sleep_active |-> !data_oe)
    else $error("pins driven asleep");
  chk_sleep_entry: assert property ($rose(sleep_req) |-> !sleep_active [*2] ##[1:6] sleep_active)
    else $error("sleep entry timing");
  chk_sleep_exit: assert property ($fell(sleep_req) |-> sleep_active [*2] ##[1:6] !sleep_active)
    else $error("sleep exit timing");
  chk_reset_idle: assert property (disable iff (1'h0) sys_rst |=> !data_oe && !sleep_active)
    else $error("not idle after reset");
endmodule

bind ftsc_core ftsc_core_props chk_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .addr_in(addr_in),
  .chip_sel_a_n(chip_sel_a_n), .chip_sel_b_hi(chip_sel_b_hi), .chip_sel_c_n(chip_sel_c_n),
  .advance_load_ctl(advance_load_ctl), .write_en_n(write_en_n),
  .byte_write_sel_lane_a_n(byte_write_sel_lane_a_n), .byte_write_sel_lane_b_n(byte_write_sel_lane_b_n),
  .out_en_n(out_en_n), .clk_en_n(clk_en_n), .sleep_req(sleep_req), .burst_order_sel(burst_order_sel),
  .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .sleep_active(sleep_active));

//--- dv/ftsc_bus_master_model.sv
module ftsc_bus_master_model (
  input wire logic clk_sys, // system clock
  input wire logic drv_en, // master drives write data
  input wire logic [ftsc_pkg::DATA_W-1:0] drv_data, // master write data
  input wire logic [ftsc_pkg::DATA_W-1:0] data_out, // device pin drive
  input wire logic data_oe, // device drives pins
  output logic [ftsc_pkg::DATA_W-1:0] data_in // resolved pin level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [ftsc_pkg::DATA_W-1:0] last_reg = 18'h00000;
  assign data_in = drv_en ? drv_data : (data_oe ? data_out : ~last_reg);
  // floating bus flips every cycle so stale data never passes for a match
  always @(posedge clk_sys) last_reg <= data_in;
endmodule

//--- dv/test_flowthrough_sram_cycle_decode.sv
module test_flowthrough_sram_cycle_decode;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'h0;
  logic sys_rst = 1'h1;
  logic [ftsc_pkg::ADDR_W-1:0] addr_in = 17'h00000;
  logic [4:0] ctl = 5'h19; // selects a, b, c, advance, write
  logic [1:0] lane_n = 2'h3;
  logic out_en_n = 1'h0;
  logic clk_en_n = 1'h0;
  logic sleep_req = 1'h0;
  logic burst_order_sel = 1'h0;
  logic drv_en = 1'h0;
  logic [17:0] drv_data = 18'h00000;
  logic [17:0] data_in, data_out;
  logic data_oe, sleep_active;
  int errors = 0;
  int checked = 0;
  int cycles = 0;
  always #50 clk_sys = ~clk_sys;
  ftsc_core dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .addr_in(addr_in), .chip_sel_a_n(ctl[4]),
    .chip_sel_b_hi(ctl[3]), .chip_sel_c_n(ctl[2]), .advance_load_ctl(ctl[1]), .write_en_n(ctl[0]),
    .byte_write_sel_lane_a_n(lane_n[0]), .byte_write_sel_lane_b_n(lane_n[1]), .out_en_n(out_en_n),
    .clk_en_n(clk_en_n), .sleep_req(sleep_req), .burst_order_sel(burst_order_sel), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .sleep_active(sleep_active));
  ftsc_bus_master_model bus_u (.clk_sys(clk_sys), .drv_en(drv_en), .drv_data(drv_data),
    .data_out(data_out), .data_oe(data_oe), .data_in(data_in));
  task automatic end_sim();
    if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'h1) begin
      errors++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  function automatic logic [17:0] dat(input logic [1:0] i);
    return 18'h2A5C3 ^ {9{i}};
  endfunction
  // one command per edge, driven just after the edge
  task automatic cyc(input logic [4:0] c, input logic [1:0] ln, input logic [16:0] a);
    @(posedge clk_sys);
    ctl <= c;
    lane_n <= ln;
    addr_in <= a;
  endtask
  task automatic t_write_burst();
    cyc(5'h08, 2'h0, 17'h00102);
    for (int i = 0; i < 4; i++) begin
      cyc(i < 3 ? 5'h1F : 5'h19, 2'h0, 17'h1FFFF);
      drv_en <= 1'h1;
      drv_data <= dat(i[1:0]);
      #1 chk(data_oe === 1'h0, "pins driven in write");
    end
    cyc(5'h19, 2'h3, 17'h00000);
    drv_en <= 1'h0;
  endtask
  task automatic t_partial_abort();
    cyc(5'h08, 2'h2, 17'h00102);
    cyc(5'h1F, 2'h3, 17'h00000);
    drv_en <= 1'h1;
    drv_data <= 18'h3FFFF;
    cyc(5'h08, 2'h3, 17'h00100);
    cyc(5'h19, 2'h3, 17'h00000);
    cyc(5'h19, 2'h3, 17'h00000);
    drv_en <= 1'h0;
  endtask
  task automatic t_read();
    logic [17:0] exp_q [3];
    logic [17:0] d0;
    d0 = dat(2'h0);
    exp_q[0] = {d0[17:9], 9'h1FF};
    exp_q[1] = dat(2'h1);
    exp_q[2] = dat(2'h2);
    burst_order_sel <= 1'h1;
    repeat (8) cyc(5'h19, 2'h3, 17'h00000);
    cyc(5'h09, 2'h3, 17'h00102);
    for (int i = 0; i < 4; i++) begin
      cyc(i < 3 ? 5'h13 : 5'h19, 2'h3, 17'h1FFFF);
      if (i == 1) clk_en_n <= 1'h1;
      if (i == 3) out_en_n <= 1'h1;
      #1 chk(data_oe === (i < 3) && (i == 3 || data_out === exp_q[i]), "read beat");
      if (i == 1) begin
        @(posedge clk_sys);
        clk_en_n <= 1'h0;
        #1 chk(data_oe === 1'h1 && data_out === exp_q[1], "stalled edge not held");
      end
    end
    cyc(5'h09, 2'h3, 17'h00102);
    cyc(5'h19, 2'h3, 17'h00000);
    #1 chk(data_oe === 1'h0, "dummy read drives");
    cyc(5'h19, 2'h3, 17'h00000);
    out_en_n <= 1'h0;
  endtask
  task automatic t_deselect();
    logic [4:0] ds [3];
    ds = '{5'h19, 5'h01, 5'h0D};
    for (int k = 0; k < 3; k++) begin
      cyc(5'h09, 2'h3, 17'h00101);
      cyc(ds[k], 2'h3, 17'h00000);
      #1 chk(data_oe === 1'h1, "read not driven");
      cyc(5'h1F, 2'h3, 17'h00000);
      #1 chk(data_oe === 1'h0, "deselect drives");
      cyc(5'h19, 2'h3, 17'h00000);
      #1 chk(data_oe === 1'h0, "advance left deselect");
    end
  endtask
  task automatic wait_sleep(input logic lvl, input logic req);
    int n;
    @(posedge clk_sys);
    sleep_req <= req;
    n = 0;
    while (sleep_active !== lvl && n < 20) begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk(n >= 2 && n < 20, "sleep transition time");
  endtask
  task automatic t_sleep();
    wait_sleep(1'h1, 1'h1);
    cyc(5'h09, 2'h3, 17'h00101);
    cyc(5'h19, 2'h3, 17'h00000);
    #1 chk(data_oe === 1'h0, "pins driven asleep");
    wait_sleep(1'h0, 1'h0);
  endtask
  // cut a hang short
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      $display("[ERR] %0t timeout", $time);
      end_sim();
    end
  end
  // main sequence
  initial begin
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'h0;
    #1 chk(data_oe === 1'h0 && sleep_active === 1'h0, "not idle after reset");
    t_write_burst();
    t_partial_abort();
    t_read();
    t_deselect();
    t_sleep();
    end_sim();
  end
endmodule
